// ---- rtl/mac_rx_dma_cfg.sv ----
`timescale 1ns/1ps

// How it works
// RL1: Discard bit writable only in full store-forward mode
// RL2: Discard clear: hold packet until buffer frees
// RL3: Discard set: drop waiting packet without buffer
// RL4: Buffer size field counts 64-byte units
// RL5: Software never writes zero buffer size
// RL6: Count non-integral bad-CRC frames of valid length
// RL7: Also count non-integral symbol-error valid-length frames
// RL8: Error counter read-only, upper bits zero
module mac_rx_dma_cfg
  import mac_rx_cfg_pkg::*;
#(
  parameter int count_w = 18
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Receive frame status from the MAC receiver
  input wire rx_frame_s rx_frame,
  // Packet buffer and system memory resource
  input wire logic rx_pkt_waiting,
  input wire logic sys_buf_available,
  output logic rx_pkt_forward,
  output logic rx_pkt_hold,
  output logic rx_pkt_drop,
  output logic [13:0] rx_buffer_bytes,
  output dma_cfg_s dma_cfg,
  // Interrupt
  output logic irq
);

  bus_state_e bus_state, next_bus_state;
  logic [11:0] bus_addr, next_bus_addr;
  logic [31:0] next_hrdata;
  logic [31:0] cfg_word, next_cfg_word;
  logic [count_w-1:0] malformed_frame_counter, next_malformed_frame_counter;
  logic [irq_bits-1:0] irq_status, next_irq_status;
  logic [irq_bits-1:0] irq_mask, next_irq_mask;
  logic max_frame_size_select, next_max_frame_size_select;
  logic next_rx_pkt_drop;
  logic next_irq;
  logic accept, wr_cfg, rd_status;
  logic count_hit, count_wrap;
  logic [13:0] len_limit;
  logic [irq_bits-1:0] events;

  assign accept = hsel && hready && (htrans == htrans_nonseq);
  assign wr_cfg = (bus_state == bus_write) && (bus_addr == rx_dma_configuration_off);
  // Clear-on-read takes effect when the read data is captured
  assign rd_status = (bus_state == bus_read_wait) && (bus_addr == irq_status_off);

  // Reads take one wait state so writes just before them are visible
  assign hreadyout = (bus_state != bus_read_wait);
  assign hresp = 1'b0;

  always_comb begin
    next_bus_state = bus_state;
    next_bus_addr = bus_addr;
    case (bus_state)
      bus_idle, bus_write, bus_read_done: begin
        if (accept) begin
          next_bus_addr = {haddr[11:2], 2'b00};
          next_bus_state = hwrite ? bus_write : bus_read_wait;
        end else begin
          next_bus_state = bus_idle;
        end
      end
      bus_read_wait: next_bus_state = bus_read_done;
      default: next_bus_state = bus_idle;
    endcase
  end

  always_comb begin
    next_hrdata = hrdata;
    if (bus_state == bus_read_wait) begin
      case (bus_addr)
        rx_dma_configuration_off: next_hrdata = cfg_word;
        rx_malformed_frame_count_off: next_hrdata = {{(32-count_w){1'b0}}, malformed_frame_counter}; // see RL8
        irq_status_off: next_hrdata = {{(32-irq_bits){1'b0}}, irq_status};
        irq_mask_off: next_hrdata = {{(32-irq_bits){1'b0}}, irq_mask};
        rx_frame_control_off: next_hrdata = {31'h0000_0000, max_frame_size_select};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_state <= bus_idle;
      bus_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      bus_addr <= next_bus_addr;
      hrdata <= next_hrdata;
    end
  end

  a_count_upper_zero: assert property (@(posedge core_clk) disable iff (rst) // see RL8
    (bus_state == bus_read_wait && bus_addr == rx_malformed_frame_count_off) |=> hrdata[31:count_w] == '0)
    else $error("Counter register upper bits not zero");

  a_status_read_clear: assert property (@(posedge core_clk) disable iff (rst)
    (rd_status && events == '0) |=> irq_status == '0)
    else $error("Status not cleared by its read");

  // Configuration and control registers
  always_comb begin
    next_cfg_word = cfg_word;
    next_irq_mask = irq_mask;
    next_max_frame_size_select = max_frame_size_select;
    if (wr_cfg) begin
      next_cfg_word = hwdata;
      // Mode in force before this write decides, not the mode being written
      if (cfg_word[rx_buffer_mode_lsb +: 2] != full_store_forward_mode) begin
        next_cfg_word[discard_rx_packets_bit] = cfg_word[discard_rx_packets_bit]; // see RL1
      end
    end
    if ((bus_state == bus_write) && (bus_addr == irq_mask_off)) begin
      next_irq_mask = hwdata[irq_bits-1:0];
    end
    if ((bus_state == bus_write) && (bus_addr == rx_frame_control_off)) begin
      next_max_frame_size_select = hwdata[0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_word <= rx_dma_configuration_rst;
      irq_mask <= '0;
      max_frame_size_select <= 1'b0;
    end else begin
      cfg_word <= next_cfg_word;
      irq_mask <= next_irq_mask;
      max_frame_size_select <= next_max_frame_size_select;
    end
  end

  a_size_write: assert property (@(posedge core_clk) disable iff (rst) // see RL4
    wr_cfg |=> dma_cfg.rx_buffer_size == $past(hwdata[rx_buffer_size_lsb +: 8]))
    else $error("Buffer size write lost");

  a_mask_write: assert property (@(posedge core_clk) disable iff (rst)
    (bus_state == bus_write && bus_addr == irq_mask_off) |=> irq_mask == $past(hwdata[irq_bits-1:0]))
    else $error("Interrupt mask write lost");

  assign dma_cfg.discard_rx_packets = cfg_word[discard_rx_packets_bit];
  assign dma_cfg.rx_buffer_size = cfg_word[rx_buffer_size_lsb +: 8];
  assign dma_cfg.rx_buffer_mode = cfg_word[rx_buffer_mode_lsb +: 2];
  // A zero size is not guarded; software must never program it
  assign rx_buffer_bytes = {dma_cfg.rx_buffer_size, 6'b00_0000}; // see RL4 RL5

  // Malformed frame counter; wraps, flagged as an event
  assign len_limit = max_frame_size_select ? max_frame_len_big : max_frame_len;
  assign count_hit = rx_frame.done && rx_frame.non_integral
                     && (rx_frame.len >= min_frame_len) && (rx_frame.len <= len_limit)
                     && (rx_frame.crc_bad || rx_frame.symbol_err); // see RL6 RL7
  assign count_wrap = count_hit && (&malformed_frame_counter);

  always_comb begin
    next_malformed_frame_counter = malformed_frame_counter;
    if (count_hit) begin
      next_malformed_frame_counter = malformed_frame_counter + 1'b1; // see RL6 RL7
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      malformed_frame_counter <= malformed_frame_counter_rst[count_w-1:0];
    end else begin
      malformed_frame_counter <= next_malformed_frame_counter;
    end
  end

  a_count_long: assert property (@(posedge core_clk) disable iff (rst) // see RL6
    (rx_frame.done && rx_frame.len > max_frame_len_big) |=> $stable(malformed_frame_counter))
    else $error("Overlong frame counted");

  a_count_integral: assert property (@(posedge core_clk) disable iff (rst) // see RL6 RL7
    (rx_frame.done && !rx_frame.non_integral) |=> $stable(malformed_frame_counter))
    else $error("Whole-byte frame counted");

  a_count_clean: assert property (@(posedge core_clk) disable iff (rst) // see RL6 RL7
    (rx_frame.done && !rx_frame.crc_bad && !rx_frame.symbol_err) |=> $stable(malformed_frame_counter))
    else $error("Frame without CRC or symbol error counted");

  a_count_limit: assert property (@(posedge core_clk) disable iff (rst) // see RL6
    (rx_frame.done && !max_frame_size_select && rx_frame.len > max_frame_len)
    |=> $stable(malformed_frame_counter))
    else $error("Frame above the normal limit counted");

  // Packet buffer release or discard
  assign rx_pkt_forward = rx_pkt_waiting && sys_buf_available;
  assign rx_pkt_hold = rx_pkt_waiting && !sys_buf_available && !dma_cfg.discard_rx_packets; // see RL2

  always_comb begin
    // Gap cycle after each drop lets the buffer retire the packet
    next_rx_pkt_drop = dma_cfg.discard_rx_packets && rx_pkt_waiting
                       && !sys_buf_available && !rx_pkt_drop; // see RL3
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_pkt_drop <= 1'b0;
    end else begin
      rx_pkt_drop <= next_rx_pkt_drop;
    end
  end

  a_hold_level: assert property (@(posedge core_clk) disable iff (rst) // see RL2
    (rx_pkt_waiting && !sys_buf_available && !dma_cfg.discard_rx_packets)
    |-> rx_pkt_hold && !rx_pkt_forward)
    else $error("Waiting packet not held while discard is clear");

  a_drop_gap: assert property (@(posedge core_clk) disable iff (rst) // see RL3
    rx_pkt_drop |=> !rx_pkt_drop)
    else $error("Drop pulse longer than one cycle");

  a_drop_cause: assert property (@(posedge core_clk) disable iff (rst) // see RL3
    rx_pkt_drop |-> $past(rx_pkt_waiting) && !$past(sys_buf_available)
    && $past(dma_cfg.discard_rx_packets))
    else $error("Packet dropped while a system buffer was free");

  a_drop_status: assert property (@(posedge core_clk) disable iff (rst) // see RL3
    rx_pkt_drop |=> irq_status[irq_dropped_bit])
    else $error("Drop did not set its status bit");

  // Sticky interrupt status; a new event wins over the read clear
  always_comb begin
    events = '0;
    events[irq_counted_bit] = count_hit;
    events[irq_dropped_bit] = rx_pkt_drop;
    events[irq_wrapped_bit] = count_wrap;
    next_irq_status = (rd_status ? '0 : irq_status) | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  a_count_status: assert property (@(posedge core_clk) disable iff (rst) // see RL6
    count_hit |=> irq_status[irq_counted_bit])
    else $error("Counted frame did not set its status bit");

  a_irq_matches: assert property (@(posedge core_clk) disable iff (rst)
    irq == |(irq_status & irq_mask))
    else $error("Interrupt level differs from unmasked status");

  a_hresp_okay: assert property (@(posedge core_clk) disable iff (rst) hresp == 1'b0)
    else $error("Slave answered other than OKAY");

  a_read_wait_one: assert property (@(posedge core_clk) disable iff (rst)
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state");

  a_discard_locked: assert property (@(posedge core_clk) disable iff (rst) // see RL1
    (wr_cfg && dma_cfg.rx_buffer_mode != full_store_forward_mode) |=> $stable(dma_cfg.discard_rx_packets))
    else $error("Discard bit changed outside full store-forward mode");

  a_discard_write: assert property (@(posedge core_clk) disable iff (rst) // see RL1
    (wr_cfg && dma_cfg.rx_buffer_mode == full_store_forward_mode)
    |=> dma_cfg.discard_rx_packets == $past(hwdata[discard_rx_packets_bit]))
    else $error("Discard bit write lost in full store-forward mode");

  a_hold_no_drop: assert property (@(posedge core_clk) disable iff (rst) // see RL2
    (!dma_cfg.discard_rx_packets && !$past(dma_cfg.discard_rx_packets)) |-> !rx_pkt_drop)
    else $error("Packet dropped while discard is clear");

  a_drop_on_starve: assert property (@(posedge core_clk) disable iff (rst) // see RL3
    (dma_cfg.discard_rx_packets && rx_pkt_waiting && !sys_buf_available && !rx_pkt_drop)
    |=> rx_pkt_drop)
    else $error("Waiting packet not dropped without a system buffer");

  a_size_bytes: assert property (@(posedge core_clk) disable iff (rst) // see RL4
    rx_buffer_bytes == 14'(dma_cfg.rx_buffer_size * 64))
    else $error("Buffer size not in 64-byte units");

  a_count_step: assert property (@(posedge core_clk) disable iff (rst) // see RL6
    count_hit |=> malformed_frame_counter == $past(malformed_frame_counter) + 1'b1)
    else $error("Malformed frame not counted");

  a_count_short: assert property (@(posedge core_clk) disable iff (rst) // see RL7
    (rx_frame.done && rx_frame.len < min_frame_len) |=> $stable(malformed_frame_counter))
    else $error("Short frame counted");

  a_count_readonly: assert property (@(posedge core_clk) disable iff (rst) // see RL8
    !count_hit |=> $stable(malformed_frame_counter))
    else $error("Counter changed without a counted frame");

  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    (rx_pkt_drop && irq_mask[irq_dropped_bit]) |=> irq ##1 (irq || !irq_status[irq_dropped_bit]))
    else $error("Unmasked drop event did not raise the interrupt");

endmodule

// ---- rtl/mac_rx_cfg_pkg.sv ----
package mac_rx_cfg_pkg;

  // Register byte offsets
  localparam logic [11:0] rx_dma_configuration_off = 12'h010;
  localparam logic [11:0] rx_malformed_frame_count_off = 12'h1a0;
  localparam logic [11:0] irq_status_off = 12'h1c0;
  localparam logic [11:0] irq_mask_off = 12'h1c4;
  localparam logic [11:0] rx_frame_control_off = 12'h1c8;

  // Reset values
  localparam logic [31:0] rx_dma_configuration_rst = 32'h0002_0004;
  localparam logic [17:0] malformed_frame_counter_rst = 18'h0_0000;

  // Field positions in rx_dma_configuration
  localparam int discard_rx_packets_bit = 24;
  localparam int rx_buffer_size_lsb = 16;
  localparam int rx_buffer_mode_lsb = 8;

  // Buffer mode code meaning full packet store and forward
  localparam logic [1:0] full_store_forward_mode = 2'h3;

  // Frame length limits in bytes
  localparam logic [13:0] min_frame_len = 14'h0040;
  localparam logic [13:0] max_frame_len = 14'h05ee;
  localparam logic [13:0] max_frame_len_big = 14'h0600;

  // Interrupt status bit positions
  localparam int irq_counted_bit = 0;
  localparam int irq_dropped_bit = 1;
  localparam int irq_wrapped_bit = 2;
  localparam int irq_bits = 3;

  // AHB encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;

  typedef struct packed {
    logic done;
    logic [13:0] len;
    logic non_integral;
    logic crc_bad;
    logic symbol_err;
  } rx_frame_s;

  typedef struct packed {
    logic discard_rx_packets;
    logic [7:0] rx_buffer_size;
    logic [1:0] rx_buffer_mode;
  } dma_cfg_s;

  typedef enum logic [1:0] {
    bus_idle,
    bus_write,
    bus_read_wait,
    bus_read_done
  } bus_state_e;

endpackage

// ---- sim/rx_link_model.sv ----
`timescale 1ns/1ps
module rx_link_model
  import mac_rx_cfg_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Drop request from the block
  input wire logic rx_pkt_drop,
  // Frame status and buffer state
  output rx_frame_s rx_frame,
  output logic rx_pkt_waiting,
  output logic sys_buf_available
);
  initial begin
    rx_frame = '0;
    rx_pkt_waiting = 1'b0;
    sys_buf_available = 1'b1;
  end
  // A dropped head packet leaves the buffer empty
  always @(posedge core_clk) begin
    if (rx_pkt_drop) begin
      rx_pkt_waiting <= 1'b0;
    end
  end
  task automatic send(input logic [13:0] l, input logic ni, c, s);
    @(posedge core_clk);
    rx_frame <= '{1'b1, l, ni, c, s};
    @(posedge core_clk);
    // Stale fields inverted so a late sample cannot match
    rx_frame <= '{1'b0, ~l, ~ni, ~c, ~s};
  endtask
  task automatic pkt(input logic w, a);
    @(posedge core_clk);
    rx_pkt_waiting <= w;
    sys_buf_available <= a;
  endtask
endmodule

// ---- sim/mac_rx_dma_config_and_error_count_tb.sv ----
`timescale 1ns/1ps
module mac_rx_dma_config_and_error_count_tb
  import mac_rx_cfg_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, rx_pkt_waiting, sys_buf_available;
  logic rx_pkt_forward, rx_pkt_hold, rx_pkt_drop, irq;
  logic [31:0] hrdata, rd;
  logic [13:0] rx_buffer_bytes;
  rx_frame_s rx_frame;
  dma_cfg_s dma_cfg;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_exp = 0;
  logic [13:0] lens [6] = '{14'h003f, 14'h0040, 14'h05ee, 14'h05ef, 14'h0600, 14'h0601};
  logic [2:0] flags [4] = '{3'h6, 3'h5, 3'h2, 3'h4};

  mac_rx_dma_cfg dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_frame(rx_frame),
    .rx_pkt_waiting(rx_pkt_waiting), .sys_buf_available(sys_buf_available),
    .rx_pkt_forward(rx_pkt_forward), .rx_pkt_hold(rx_pkt_hold), .rx_pkt_drop(rx_pkt_drop),
    .rx_buffer_bytes(rx_buffer_bytes), .dma_cfg(dma_cfg), .irq(irq));
  rx_link_model link (.core_clk(core_clk), .rx_pkt_drop(rx_pkt_drop), .rx_frame(rx_frame),
    .rx_pkt_waiting(rx_pkt_waiting), .sys_buf_available(sys_buf_available));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // hreadyout comes from flops, so the value at negedge is the one the next edge samples
  task automatic rdy();
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    @(posedge core_clk);
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, rx_dma_configuration_off, '0);
    chk(rd, 32'h0002_0004);
    chk(rx_buffer_bytes, 14'h0080);
    xfer(1'b0, rx_malformed_frame_count_off, '0);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h100, '0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, rx_frame_control_off, 32'(m));
      foreach (lens[i]) foreach (flags[j]) begin
        link.send(lens[i], flags[j][2], flags[j][1], flags[j][0]);
        if (flags[j][2] && flags[j][1:0] != 2'h0 && lens[i] >= 14'h0040 &&
            lens[i] <= (m == 1 ? 14'h0600 : 14'h05ee)) n_exp++;
      end
    end
    xfer(1'b0, rx_malformed_frame_count_off, '0);
    chk(rd, n_exp);
    xfer(1'b1, rx_malformed_frame_count_off, 32'hffff_ffff);
    xfer(1'b0, rx_malformed_frame_count_off, '0);
    chk(rd, n_exp);
    xfer(1'b0, irq_status_off, '0);
    chk(rd, 32'h1);
    xfer(1'b1, irq_mask_off, 32'h1);
    link.send(14'h0040, 1'b1, 1'b1, 1'b0);
    repeat (3) @(negedge core_clk);
    chk(irq, 1'b1);
    @(posedge core_clk);
    xfer(1'b0, irq_status_off, '0);
    chk(rd, 32'h1);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b0);
    link.pkt(1'b1, 1'b0);
    repeat (3) @(negedge core_clk);
    chk(rx_pkt_hold, 1'b1);
    chk(rx_pkt_drop, 1'b0);
    link.pkt(1'b1, 1'b1);
    @(negedge core_clk);
    chk(rx_pkt_forward, 1'b1);
    link.pkt(1'b0, 1'b1);
    xfer(1'b1, rx_dma_configuration_off, 32'h0102_0004);
    xfer(1'b0, rx_dma_configuration_off, '0);
    chk(rd, 32'h0002_0004);
    // Size stays non-zero on every write
    xfer(1'b1, rx_dma_configuration_off, 32'h0018_0300);
    xfer(1'b1, rx_dma_configuration_off, 32'h0118_0300);
    xfer(1'b0, rx_dma_configuration_off, '0);
    chk(rd, 32'h0118_0300);
    chk(dma_cfg, {1'b1, 8'h18, 2'h3});
    chk(rx_buffer_bytes, 14'h0600);
    xfer(1'b0, irq_status_off, '0);
    chk(rd, 32'h0);
    xfer(1'b1, irq_mask_off, 32'h2);
    link.pkt(1'b1, 1'b0);
    for (int i = 0; i < 8 && rx_pkt_drop !== 1'b1; i++) @(negedge core_clk);
    chk(rx_pkt_drop, 1'b1);
    chk(rx_pkt_hold, 1'b0);
    @(negedge core_clk);
    chk(rx_pkt_drop, 1'b0);
    chk(irq, 1'b1);
    @(posedge core_clk);
    xfer(1'b0, irq_status_off, '0);
    chk(rd, 32'h2);
    @(negedge core_clk);
    chk(irq, 1'b0);
    final_report();
  end
endmodule
